// ### logic/wdt_params.svh
/*
  Constant header of the windowed watchdog: register offsets, field positions,
  reset values and timing counts.
  Assumes it is included by bare name from the package; the design file has no include and uses the macros it leaves.
*/
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define WDT_CFG_OFS      12'h000
`define WDT_CAUSE_OFS    12'h004
`define WDT_CMD_OFS      12'h008
`define WDT_IRQ_STAT_OFS 12'h00C
`define WDT_IRQ_MASK_OFS 12'h010
`define WDT_COUNT_OFS    12'h014

// ****************************************************************
// Field positions.
// ****************************************************************
`define WDT_CFG_POST_LSB  0
`define WDT_CFG_PRE_BIT   4
`define WDT_CFG_WIN_BIT   6
`define WDT_CFG_HARD_BIT  7
`define WDT_CAUSE_IDLE    2
`define WDT_CAUSE_SLEEP   3
`define WDT_CAUSE_TO      4
`define WDT_CAUSE_SWEN    5
`define WDT_CMD_CLR       0
`define WDT_CMD_SLEEP     1
`define WDT_CMD_IDLE      2
`define WDT_CMD_WAKE      3
`define WDT_CMD_CLKSW     4
`define WDT_EV_TIMEOUT    0
`define WDT_EV_WAKE       1
`define WDT_EV_EARLY      2

// ****************************************************************
// Reset values.
// ****************************************************************
`define WDT_CFG_RST       8'h4F
`define WDT_MASK_RST      3'h0

// ****************************************************************
// Timing: 10 MHz system clock, 32 kHz oscillator.
// ****************************************************************
`define WDT_SYS_CLK_HZ    10_000_000
`define WDT_LOW_POWER_RC_OSC_HZ       32_000
`define WDT_LOW_POWER_RC_OSC_HALF     (`WDT_SYS_CLK_HZ / (2 * `WDT_LOW_POWER_RC_OSC_HZ))
`define WDT_PRE_SHORT     32
`define WDT_PRE_LONG      128
`define WDT_RESET_CYCLES  16

`endif

// ### logic/wdt_pkg.sv
/*
  Types of the windowed watchdog.
  Assumes wdt_params.svh is on the include path.
*/
`include "wdt_params.svh"

package wdt_pkg;

  // Processor core instruction strobes, one cycle each.
  typedef struct packed {
    logic clr;
    logic sleep;
    logic idle;
    logic wake;
    logic clk_switch;
  } wdt_core_cmd_t;

  // Power state of the core as seen by the watchdog.
  typedef enum logic [2:0] {
    WDT_RUN   = 3'b001,
    WDT_SLEEP = 3'b010,
    WDT_IDLE  = 3'b100
  } wdt_pwr_t;

  // Indications back to the core.
  typedef struct packed {
    logic wake_pulse;
    logic reset_req;
  } wdt_core_ind_t;

endpackage : wdt_pkg

// ### logic/wdt_top.sv
/*
  Windowed watchdog timer with APB register access and one interrupt line.
  Assumes a 10 MHz pclk, an APB master, and a processor core that issues
  one-cycle instruction strobes on the same clock.
  Read data and the error answer are taken in the APB setup cycle, so a
  register that changes in that very cycle is reported one cycle late.
  The low-power oscillator is modelled as a tick divided from pclk, and the
  watchdog reset request is handed to the core as a level of fixed length.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - The counter runs from the low-power RC oscillator, which is on whenever the watchdog is.
// - The prescaler divides the 32 kHz clock by 32 or by 128 per the prescale select bit.
// - Without postscaling the timeout is 1 ms in 5-bit mode and 4 ms in 7-bit mode.
// - A 4-bit postscale select picks a ratio from 1:1 to 1:32768 in powers of two.
// - Device reset and a finished clock switch clear counter, prescaler and postscaler.
// - A power-save instruction clears counter, prescaler and postscaler.
// - Leaving sleep or idle clears counter, prescaler and postscaler.
// - A clear instruction in normal execution clears counter, prescaler and postscaler.
// - An enabled watchdog keeps counting in sleep and idle.
// - A timeout in sleep or idle wakes the core instead of resetting it.
// - With the hard enable bit set the watchdog always runs.
// - With the hard enable bit clear the watchdog runs only while the soft enable bit is set.
// - Only presetn or a write to the reset-cause register clears the soft enable bit; the watchdog's own reset request leaves it set.
// - In window mode a clear before the last quarter of the period resets the device; not with the 128 prescaler at 1:32768, where the period wraps to zero.
// - Hardware sets the timeout flag and never clears it; software clears it.
module wdt_top #(
  parameter int POST_W = 15
) (
  // Clock and reset.
  input  wire  logic                   pclk,
  input  wire  logic                   presetn,
  // APB slave.
  input  wire  logic                   psel,
  input  wire  logic                   penable,
  input  wire  logic                   pwrite,
  input  wire  logic [11:0]            paddr,
  input  wire  logic [31:0]            pwdata,
  output logic       [31:0]            prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Processor core.
  input  wire  wdt_pkg::wdt_core_cmd_t core_cmd,
  output wdt_pkg::wdt_core_ind_t       core_ind,
  output logic                         osc_enable,
  // Interrupt.
  output logic                         irq
);
  import wdt_pkg::*;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0]        cfg_r;
  logic              soft_en_r;
  logic              flag_to_r;
  logic              flag_sleep_r;
  logic              flag_idle_r;
  logic [2:0]        stat_r;
  logic [2:0]        mask_r;
  wdt_pwr_t          pwr_r;
  logic              wd_en;
  logic              wr_en;
  logic              rd_en;
  logic              apb_clr;
  logic              apb_sleep;
  logic              apb_idle;
  logic              apb_wake;
  logic              apb_clksw;
  wdt_core_cmd_t     cmd;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;

  assign apb_clr   = wr_en && (paddr == `WDT_CMD_OFS) && pwdata[`WDT_CMD_CLR];
  assign apb_sleep = wr_en && (paddr == `WDT_CMD_OFS) && pwdata[`WDT_CMD_SLEEP];
  assign apb_idle  = wr_en && (paddr == `WDT_CMD_OFS) && pwdata[`WDT_CMD_IDLE];
  assign apb_wake  = wr_en && (paddr == `WDT_CMD_OFS) && pwdata[`WDT_CMD_WAKE];
  assign apb_clksw = wr_en && (paddr == `WDT_CMD_OFS) && pwdata[`WDT_CMD_CLKSW];

  // Core strobes and the command register act the same way.
  assign cmd.clr        = core_cmd.clr || apb_clr;
  assign cmd.sleep      = core_cmd.sleep || apb_sleep;
  assign cmd.idle       = core_cmd.idle || apb_idle;
  assign cmd.wake       = core_cmd.wake || apb_wake;
  assign cmd.clk_switch = core_cmd.clk_switch || apb_clksw;

  assign wd_en      = cfg_r[`WDT_CFG_HARD_BIT] || soft_en_r;
  assign osc_enable = wd_en;

  // ****************************************************************
  // Low-power oscillator model: a 32 kHz enable from the system clock.
  // ****************************************************************
  localparam int OSC_HALF = `WDT_LOW_POWER_RC_OSC_HALF;
  localparam int OSC_W    = $clog2(2 * OSC_HALF + 1);
  logic [OSC_W-1:0] osc_cnt_r;
  logic             osc_tick;

  assign osc_tick = wd_en && (osc_cnt_r == OSC_W'(2 * OSC_HALF - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_r <= '0;
    end else if (!wd_en || osc_tick) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + OSC_W'(1);
    end
  end

  // ****************************************************************
  // Prescaler, postscaler and window.
  // ****************************************************************
  logic [6:0]        pre_r;
  logic [POST_W-1:0] post_r;
  logic              pre_done;
  logic [POST_W-1:0] post_last;
  logic              timeout;
  logic              cnt_clear;
  logic              in_window;
  logic              early_clr;
  logic [POST_W+6:0] elapsed;
  logic [POST_W+6:0] period;

  assign pre_done = osc_tick && (cfg_r[`WDT_CFG_PRE_BIT]
                    ? (pre_r == 7'(`WDT_PRE_LONG - 1))
                    : (pre_r == 7'(`WDT_PRE_SHORT - 1)));
  assign post_last = POST_W'((1 << cfg_r[3:0]) - 1);
  assign timeout   = wd_en && pre_done && (post_r == post_last);

  // Position in the period, in oscillator ticks, for the window check.
  assign elapsed = cfg_r[`WDT_CFG_PRE_BIT]
                 ? {post_r, pre_r} : {2'b00, post_r, pre_r[4:0]};
  assign period  = cfg_r[`WDT_CFG_PRE_BIT]
                 ? (POST_W + 7)'(128) << cfg_r[3:0]
                 : (POST_W + 7)'(32) << cfg_r[3:0];
  // A clear in the first three quarters of the period is early, except with the 128 prescaler at 1:32768; it still restarts the count.
  assign in_window = (elapsed >= (period - (period >> 2)));
  assign early_clr = wd_en && cmd.clr && (pwr_r == WDT_RUN)
                     && !cfg_r[`WDT_CFG_WIN_BIT] && !in_window;

  logic clr_switch;
  logic clr_enter;
  logic clr_exit;
  logic clr_instr;

  assign clr_switch = cmd.clk_switch;
  assign clr_enter  = cmd.sleep || cmd.idle;
  assign clr_exit   = cmd.wake && (pwr_r != WDT_RUN);
  assign clr_instr  = cmd.clr && (pwr_r == WDT_RUN);

  // A disabled watchdog holds its count at zero, and a timeout restarts it.
  assign cnt_clear = !wd_en || clr_switch || clr_enter || clr_exit || clr_instr || timeout;

  // Prescaler: counts oscillator ticks up to the selected divide ratio.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (cnt_clear || pre_done) begin
      pre_r <= '0;
    end else if (osc_tick) begin
      pre_r <= pre_r + 7'(1);
    end
  end

  // Postscaler: counts completed prescaler rounds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_r <= '0;
    end else if (cnt_clear) begin
      post_r <= '0;
    end else if (pre_done) begin
      post_r <= post_r + POST_W'(1);
    end
  end

  // ****************************************************************
  // Power state, wake and device reset request.
  // ****************************************************************
  logic to_run;
  logic to_sleep;
  logic rst_fire;
  logic [4:0] rst_cnt_r;
  logic       wake_r;

  assign to_run   = timeout && (pwr_r == WDT_RUN);
  assign to_sleep = timeout && (pwr_r != WDT_RUN);
  assign rst_fire = to_run || early_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= WDT_RUN;
    end else if (to_sleep || cmd.wake) begin
      pwr_r <= WDT_RUN;
    end else if (cmd.sleep) begin
      pwr_r <= WDT_SLEEP;
    end else if (cmd.idle) begin
      pwr_r <= WDT_IDLE;
    end
  end

  // Wake is a registered one-cycle pulse; both indication fields are driven by assigns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= to_sleep;
    end
  end
  assign core_ind.wake_pulse = wake_r;

  // Reset request is held for a fixed number of cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= '0;
    end else if (rst_fire) begin
      rst_cnt_r <= 5'(`WDT_RESET_CYCLES);
    end else if (rst_cnt_r != 5'd0) begin
      rst_cnt_r <= rst_cnt_r - 5'd1;
    end
  end
  assign core_ind.reset_req = (rst_cnt_r != 5'd0);

  // ****************************************************************
  // Configuration and reset-cause registers.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `WDT_CFG_RST;
    end else if (wr_en && paddr == `WDT_CFG_OFS) begin
      cfg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_en_r <= 1'b0;
    end else if (wr_en && paddr == `WDT_CAUSE_OFS) begin
      soft_en_r <= pwdata[`WDT_CAUSE_SWEN];
    end
  end

  // In each flag below a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_to_r <= 1'b0;
    end else if (timeout) begin
      flag_to_r <= 1'b1;
    end else if (wr_en && paddr == `WDT_CAUSE_OFS) begin
      flag_to_r <= pwdata[`WDT_CAUSE_TO] & flag_to_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_sleep_r <= 1'b0;
    end else if (cmd.sleep) begin
      flag_sleep_r <= 1'b1;
    end else if (wr_en && paddr == `WDT_CAUSE_OFS) begin
      flag_sleep_r <= pwdata[`WDT_CAUSE_SLEEP] & flag_sleep_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_idle_r <= 1'b0;
    end else if (cmd.idle) begin
      flag_idle_r <= 1'b1;
    end else if (wr_en && paddr == `WDT_CAUSE_OFS) begin
      flag_idle_r <= pwdata[`WDT_CAUSE_IDLE] & flag_idle_r;
    end
  end

  // ****************************************************************
  // Interrupt status and mask.
  // ****************************************************************
  logic [2:0] ev;
  logic       stat_rd;
  logic [31:0] prdata_r;

  assign ev      = {early_clr, to_sleep, timeout};
  assign stat_rd = rd_en && (paddr == `WDT_IRQ_STAT_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else if (stat_rd) begin
      // Only the reported bits clear, so an event after the capture is kept.
      stat_r <= (stat_r & ~prdata_r[2:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `WDT_MASK_RST;
    end else if (wr_en && paddr == `WDT_IRQ_MASK_OFS) begin
      mask_r <= pwdata[2:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // ****************************************************************
  // APB read data and error answer.
  // ****************************************************************
  logic [31:0] rd_nxt;
  logic        err_nxt;

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == `WDT_CFG_OFS) begin
      rd_nxt[7:0] = cfg_r;
    end else if (paddr == `WDT_CAUSE_OFS) begin
      rd_nxt[`WDT_CAUSE_SWEN]  = soft_en_r;
      rd_nxt[`WDT_CAUSE_TO]    = flag_to_r;
      rd_nxt[`WDT_CAUSE_SLEEP] = flag_sleep_r;
      rd_nxt[`WDT_CAUSE_IDLE]  = flag_idle_r;
    end else if (paddr == `WDT_CMD_OFS) begin
      rd_nxt[2:0] = pwr_r;
    end else if (paddr == `WDT_IRQ_STAT_OFS) begin
      rd_nxt[2:0] = stat_r;
    end else if (paddr == `WDT_IRQ_MASK_OFS) begin
      rd_nxt[2:0] = mask_r;
    end else if (paddr == `WDT_COUNT_OFS) begin
      rd_nxt[POST_W+6:0] = elapsed;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // Read data and the error answer are captured in the setup cycle, so both
  // leave flip-flops (the error answer gated with psel and penable) and stand unchanged through the whole access phase.
  logic setup_ph;
  logic err_r;

  assign setup_ph = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_nxt;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (setup_ph) begin
      err_r <= err_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = psel && penable && err_r;

endmodule // wdt_top

`default_nettype wire

// ### verification/wdt_chk.sv
/*
  Port checker of the watchdog top, bound to it at the foot of the file.
  Assumes zero wait state APB and one-cycle core strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module wdt_chk (
  // Clock and reset.
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB.
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pslverr,
  // Core and interrupt.
  input wire wdt_pkg::wdt_core_cmd_t core_cmd,
  input wire wdt_pkg::wdt_core_ind_t core_ind,
  input wire logic                   osc_enable,
  input wire logic                   irq
);
  import wdt_pkg::*;
  logic        wr, hard_r, win_r, pre_r, swen_r;
  logic [3:0]  post_r;
  logic [2:0]  mask_r;
  logic [31:0] since_r, per;
  assign wr  = psel & penable & pwrite;
  assign per = ((pre_r ? 32'h0000_0080 : 32'h0000_0020) << post_r) * 32'h0000_0138;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hard_r, win_r, pre_r, post_r} <= 7'h2F;
      swen_r <= 1'h0;
      mask_r <= 3'h0;
    end else if (wr && paddr == 12'h000) begin
      {hard_r, win_r, pre_r, post_r} <= {pwdata[7:6], pwdata[4:0]};
    end else if (wr && paddr == 12'h004) begin
      swen_r <= pwdata[5];
    end else if (wr && paddr == 12'h010) begin
      mask_r <= pwdata[2:0];
    end
  end
  // Cycles since the count was last restarted by a strobe, an event or disabling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 32'h0;
    end else if (!(hard_r | swen_r) || core_cmd != '0 || core_ind != '0) begin
      since_r <= 32'h0;
    end else begin
      since_r <= since_r + 32'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  hard_keeps_on_a: assert property (hard_r |-> osc_enable)
    else $error("hard enable set but oscillator off");
  all_off_a: assert property (!hard_r && !swen_r |-> !osc_enable)
    else $error("oscillator on while both enables clear");
  early_clear_a: assert property (core_cmd.clr && !win_r && (hard_r || swen_r)
    && since_r < 32'd100 |=> core_ind.reset_req) else $error("early clear did not reset");
  late_clear_a: assert property (core_cmd.clr && win_r && !core_ind.reset_req
    |=> !core_ind.reset_req) else $error("clear with window off caused reset");
  reset_length_a: assert property ($rose(core_ind.reset_req) |-> core_ind.reset_req [*8]
    ##1 core_ind.reset_req [*8] ##1 !core_ind.reset_req) else $error("reset request length");
  wake_only_a: assert property (core_ind.wake_pulse |-> !core_ind.reset_req
    ##1 !core_ind.wake_pulse) else $error("wake pulse wrong");
  period_bound_a: assert property (since_r <= per + 32'h0000_02BC)
    else $error("no timeout within the period");
  irq_masked_a: assert property (mask_r == 3'h0 |-> !irq)
    else $error("interrupt with all events masked");
  unmapped_a: assert property (psel && penable && !(paddr inside {12'h000, 12'h004,
    12'h008, 12'h00C, 12'h010, 12'h014}) |-> pslverr) else $error("unmapped access accepted");
  cover property ($rose(core_ind.reset_req));
  cover property (core_ind.wake_pulse);
  cover property (core_cmd.clr && !win_r);
  cover property (irq && mask_r == 3'h1);
endmodule // wdt_chk
bind wdt_top wdt_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .core_cmd(core_cmd),
  .core_ind(core_ind), .osc_enable(osc_enable), .irq(irq));
`default_nettype wire

// ### verification/wdt_core_model.sv
/*
  Processor core model: turns bench requests into one-cycle instruction strobes.
  Assumes it shares pclk and presetn with the watchdog.
*/
`timescale 1ns/100ps
`default_nettype none
module wdt_core_model (
  // Clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Bench requests.
  input  wire wdt_pkg::wdt_core_cmd_t req,
  // Watchdog side.
  input  wire wdt_pkg::wdt_core_ind_t ind,
  output wdt_pkg::wdt_core_cmd_t      cmd
);
  import wdt_pkg::*;
  logic asleep;
  // A sleeping or idle core passes on only wake and clock switch strobes; a wake request or a watchdog wake pulse leaves that state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd    <= '0;
      asleep <= 1'h0;
    end else begin
      cmd.clr        <= req.clr & ~asleep;
      cmd.sleep      <= req.sleep & ~asleep;
      cmd.idle       <= req.idle & ~asleep;
      cmd.wake       <= req.wake & asleep;
      cmd.clk_switch <= req.clk_switch;
      asleep         <= (asleep & ~ind.wake_pulse & ~req.wake) | req.sleep | req.idle;
    end
  end
endmodule // wdt_core_model
`default_nettype wire

// ### verification/windowed_watchdog_timer_tb.sv
/*
  Self-checking bench of the watchdog: APB tasks, core model, timed checks.
  Assumes the package, design, core model and checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_tb;
  import wdt_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err, osc_enable, irq;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [4:0]    req, sel;
  wdt_core_cmd_t cmd;
  wdt_core_ind_t ind;
  int            bad_count, checks, n, per, k;
  wdt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_cmd(cmd), .core_ind(ind), .osc_enable(osc_enable), .irq(irq));
  wdt_core_model core (.pclk(pclk), .presetn(presetn), .req(req), .ind(ind), .cmd(cmd));
  always #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                       input string what);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e, what);
  endtask
  task automatic pulse(input logic [4:0] c);
    @(posedge pclk);
    req <= c;
    @(posedge pclk);
    req <= 5'h0;
  endtask
  task automatic meas;
    n = 0;
    while (ind === 2'h0) begin
      @(posedge pclk);
      n++;
    end
  endtask
  function automatic int period(input logic [4:0] s);
    return ((s[4] ? 128 : 32) << s[3:0]) * 312;
  endfunction
  function automatic logic near(input int seen, input int exp);
    return seen > exp - 700 && seen < exp + 700;
  endfunction
  task automatic wrap_up;
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #9_600_000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, req, paddr, pwdata} = '0;
    bad_count = 0;
    checks = 0;
    n = $urandom(21831);
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(12'h000, 32'h0000_004F, 32'h0000_00DF, "cfg reset");
    rdchk(12'h004, 32'h0000_0000, 32'h0000_003C, "cause reset");
    chk(osc_enable, 1'h0, "osc after reset");
    apb(1'h0, 12'h0FC, 32'h0);
    chk(err, 1'h1, "unmapped error");
    chk(pready, 1'h1, "pready zero wait");
    apb(1'h1, 12'h010, 32'h0000_0007);
    apb(1'h1, 12'h000, 32'h0000_0000);
    apb(1'h1, 12'h004, 32'h0000_0020);
    chk(osc_enable, 1'h1, "soft enable");
    repeat ($urandom_range(40, 5)) @(posedge pclk);
    pulse(5'h10);
    meas();
    chk(n < 6, 1'h1, "early clear reset");
    chk(irq, 1'h1, "irq raised");
    repeat (20) @(posedge pclk);
    rdchk(12'h00C, 32'h0000_0004, 32'h0000_0004, "early event");
    chk(irq, 1'h0, "irq cleared by read");
    sel = 5'($urandom_range(2, 0));
    if (sel == 5'h2)
      sel = 5'h10;
    per = period(sel);
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h000, 32'h0000_0040 | 32'(sel));
    apb(1'h1, 12'h004, 32'h0000_0020);
    pulse(5'h10);
    meas();
    chk(near(n, per), 1'h1, "run timeout span");
    chk(ind.reset_req, 1'h1, "run timeout resets");
    repeat (20) @(posedge pclk);
    rdchk(12'h004, 32'h0000_0010, 32'h0000_0010, "flag kept");
    apb(1'h1, 12'h004, 32'h0000_0020);
    rdchk(12'h004, 32'h0, 32'h0000_0010, "flag cleared");
    per = period(5'h0);
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h000, 32'h0000_0040);
    apb(1'h1, 12'h004, 32'h0000_0020);
    pulse(5'h10);
    repeat ($urandom_range(7000, 2000)) @(posedge pclk);
    pulse(5'h10);
    rdchk(12'h014, 32'h0, 32'hFFFF_FFFE, "count after clear");
    repeat (6000) @(posedge pclk);
    chk(ind, 2'h0, "no timeout after clear");
    meas();
    chk(near(n, per - 6000), 1'h1, "timeout after clear");
    apb(1'h1, 12'h010, 32'h0000_0004);
    for (k = 0; k < 2; k++) begin
      repeat (3000) @(posedge pclk);
      pulse(k ? 5'h04 : 5'h08);
      rdchk(12'h008, k ? 32'h4 : 32'h2, 32'h7, "power state");
      meas();
      chk(near(n, per), 1'h1, "sleep timeout span");
      chk(ind.wake_pulse, 1'h1, "wake not reset");
      chk(irq, 1'h0, "wake masked");
      rdchk(12'h008, 32'h1, 32'h7, "back to run");
      rdchk(12'h004, k ? 32'h24 : 32'h28, 32'h2C, "power flag");
      apb(1'h1, 12'h004, 32'h0000_0020);
      rdchk(12'h004, 32'h20, 32'h2C, "power flag cleared");
      rdchk(12'h00C, 32'h2, 32'h2, "wake event");
    end
    pulse(5'h04);
    repeat (3000) @(posedge pclk);
    pulse(5'h02);
    rdchk(12'h014, 32'h0, 32'hFFFF_FFFE, "count after wake");
    repeat (3000) @(posedge pclk);
    pulse(5'h01);
    rdchk(12'h014, 32'h0, 32'hFFFF_FFFE, "count after switch");
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h000, 32'h0000_00C0);
    chk(osc_enable, 1'h1, "hard enable");
    apb(1'h1, 12'h000, 32'h0000_0040);
    chk(osc_enable, 1'h0, "all disabled");
    wrap_up();
  end
endmodule // windowed_watchdog_timer_tb
`default_nettype wire
